// ---- core/cell_pkg.sv ----
/*
 Shared constants of the configurable logic cell: register offsets,
 configuration word and control fields, reset values, ALU and shifter
 codes. Assumes byte-wide register access with an 8-bit address.
*/
package cell_pkg;
  localparam logic [7:0] OFS_ACC0   = 8'h00;
  localparam logic [7:0] OFS_ACC1   = 8'h01;
  localparam logic [7:0] OFS_DAT0   = 8'h02;
  localparam logic [7:0] OFS_DAT1   = 8'h03;
  localparam logic [7:0] OFS_FIFO0  = 8'h04;
  localparam logic [7:0] OFS_FIFO1  = 8'h05;
  localparam logic [7:0] OFS_CTRL   = 8'h06;
  localparam logic [7:0] OFS_STAT   = 8'h07;
  localparam logic [7:0] OFS_CMASK0 = 8'h08;
  localparam logic [7:0] OFS_CMASK1 = 8'h09;
  localparam logic [7:0] OFS_OMASK  = 8'h0A;
  localparam logic [7:0] OFS_AREG   = 8'h0B;
  localparam logic [7:0] OFS_CMPSEL = 8'h0C;
  localparam logic [7:0] OFS_OSEL   = 8'h0D;
  localparam logic [7:0] OFS_CRAM   = 8'h10;
  localparam logic [7:0] OFS_ARR    = 8'h40;
  localparam logic [7:0] RST_DATA   = 8'h00;
  localparam logic [7:0] RST_CMASK  = 8'hFF;
  localparam int CFG_FN = 0;
  localparam int CFG_SA = 3;
  localparam int CFG_SB = 4;
  localparam int CFG_SH = 6;
  localparam int CFG_CREG = 8;
  localparam int CFG_DST = 9;
  localparam int CFG_LD = 11;
  localparam int CFG_CAP = 12;
  localparam int CFG_CRC = 14;
  localparam int CFG_OM = 15;
  localparam int CT_DIR = 0;
  localparam int CT_MSB = 2;
  localparam int CT_CHAIN = 5;
  localparam int CT_CAPACC = 6;
  localparam int CT_CIN = 7;
  localparam int ARR_IN = 12;
  localparam int ARR_PT = 8;
  localparam int ARR_OUT = 4;
  localparam int ARR_STRIDE = 4;
  localparam int ARR_SPAN = 32;
  localparam int FIFO_DEPTH = 4;
  localparam int NUM_ROUTE = 6;
  typedef enum logic [2:0] {ALU_INC, ALU_DEC, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_PASS} alu_fn_t;
  typedef enum logic [1:0] {SH_NONE, SH_LEFT, SH_RIGHT, SH_SWAP} shift_t;
endpackage

// ---- core/logic_cell.sv ----
/*
 Configurable logic cell: two product term arrays, an 8-bit datapath
 with ALU, shifter, compares, CRC step, config store, two byte FIFOs.
 Assumes one clock, a byte-wide register port driven by the system
 bus, and routing/neighbour cells on the route and chain ports.
*/
// Behaviour
// RULE_01: two arrays, registered or direct sum-of-products
// RULE_02: twelve inputs shared by eight product terms
// RULE_03: term ANDs chosen true/complement inputs
// RULE_04: output ORs any of eight terms
// RULE_05: four outputs, each registered or combinational
// RULE_06: ALU op on 8-bit operands, one cycle
// RULE_07: accumulators: ALU source, destination, compare source
// RULE_08: data registers: sources only, never ALU destination
// RULE_09: two four-byte FIFOs load or capture
// RULE_10: eight 16-bit configs, routed address per cycle
// RULE_11: eight ALU functions including pass
// RULE_12: shift left/right, nibble swap, OR mask
// RULE_13: two masked compares, selectable operand pairs
// RULE_14: zero, ones, overflow; selectable routing outputs
// RULE_15: compare results chain to neighbour cells
// RULE_16: programmable msb for arithmetic and shift
// RULE_17: one CRC/PSEUDO_RANDOM_SEQUENCE step per cycle, programmable
// RULE_18: wider CRC/PSEUDO_RANDOM_SEQUENCE via chaining or arrays
// RULE_19: each FIFO input or output buffer
// RULE_20: FIFO status selectable onto routing outputs
// RULE_21: carry, shift, conditions chain to neighbours
// RULE_22: six routing inputs, six routing outputs
// RULE_23: carry and shift-out registered, reusable later
// RULE_24: bus avoids full input, empty output FIFO
// RULE_25: working registers bus readable and writable
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  // depth must be a power of two so the pointers wrap naturally
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  assign in_ready  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem_q[rp_q];
  always_ff @(posedge clk_sys) begin
    if (push)
      mem_q[wp_q] <= in_data;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_q + (AW)'(push);
      rp_q  <= rp_q + (AW)'(pop);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  chk_fifo_depth: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_09
    cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

module logic_datapath_cell
  import cell_pkg::*;
#(
  parameter int FDEPTH = FIFO_DEPTH
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           sys_addr,
  input  wire logic                 sys_wr,
  input  wire logic                 sys_rd,
  input  wire logic [7:0]           sys_wdata,
  output logic      [7:0]           sys_rdata,
  output logic      [1:0]           sys_fifo_ready,
  input  wire logic [NUM_ROUTE-1:0] route_in,
  output logic      [NUM_ROUTE-1:0] route_out,
  input  wire logic [ARR_IN-1:0]    arr0_in,
  input  wire logic [ARR_IN-1:0]    arr1_in,
  output logic      [ARR_OUT-1:0]   arr0_out,
  output logic      [ARR_OUT-1:0]   arr1_out,
  input  wire logic                 chain_carry_in,
  input  wire logic                 chain_shift_in,
  input  wire logic                 chain_eq_in,
  input  wire logic                 chain_lt_in,
  output logic                      chain_carry_out,
  output logic                      chain_shift_out,
  output logic                      chain_eq_out,
  output logic                      chain_lt_out
);
  logic [7:0]         acc_q [2];
  logic [7:0]         dat_q [2];
  logic [7:0]         acc_d [2];
  logic [7:0]         dat_d [2];
  logic [7:0]         ctrl_q;
  logic [7:0]         cmask_q [2];
  logic [7:0]         omask_q;
  logic [7:0]         areg_q;
  logic [7:0]         cmpsel_q;
  logic [7:0]         osel_q [3];
  logic [7:0]         cram_q [16];
  logic [7:0]         arr_q [64];
  logic [ARR_OUT-1:0] sop_q [2];
  logic               carry_q;
  logic               shout_q;
  logic               ovf_q;
  logic [7:0]         rdata_q;

  // register port decode
  logic [15:0]        we;
  logic [7:0]         low_v [16];
  wire                hit_low  = sys_addr[7:4] == OFS_ACC0[7:4];
  wire                hit_cram = sys_addr[7:4] == OFS_CRAM[7:4];
  wire                hit_arr  = sys_addr[7:6] == OFS_ARR[7:6];
  wire [7:0]          rd_mux   = hit_arr ? arr_q[sys_addr[5:0]] :
                                 hit_cram ? cram_q[sys_addr[3:0]] :
                                 hit_low ? low_v[sys_addr[3:0]] : 8'h00;
  for (genvar k = 0; k < 16; k++) begin : g_we
    assign we[k] = sys_wr && hit_low && sys_addr[3:0] == 4'(k);
  end

  // dynamic configuration word
  wire [2:0]   cfg_addr = route_in[2:0];
  wire [15:0]  cfg      = {cram_q[{cfg_addr, 1'b1}], cram_q[{cfg_addr, 1'b0}]}; // RULE_10 RULE_22
  alu_fn_t     fn;
  shift_t      sh;
  assign fn = alu_fn_t'(cfg[CFG_FN +: 3]);
  assign sh = shift_t'(cfg[CFG_SH +: 2]);
  wire [1:0]   sb   = cfg[CFG_SB +: 2];
  wire [1:0]   dst  = cfg[CFG_DST +: 2];
  wire         ld   = cfg[CFG_LD];
  wire [1:0]   cap  = cfg[CFG_CAP +: 2];
  wire [1:0]   dir  = ctrl_q[CT_DIR +: 2];
  wire [2:0]   msb  = ctrl_q[CT_MSB +: 3];
  wire         chen = ctrl_q[CT_CHAIN];

  // operands and masks
  wire [7:0]   src_a = acc_q[cfg[CFG_SA]]; // RULE_07
  wire [7:0]   src_b = sb[1] ? acc_q[sb[0]] : dat_q[sb[0]]; // RULE_08
  wire [7:0]   wmask = 8'hFF >> (3'd7 - msb); // RULE_16
  wire [7:0]   a_m   = src_a & wmask;
  wire [7:0]   b_m   = src_b & wmask;
  // registered carry and shift bits allow 16-bit work on one datapath
  wire         cin   = cfg[CFG_CREG] ? carry_q : chen ? chain_carry_in : ctrl_q[CT_CIN]; // RULE_23 RULE_21
  wire         sin   = cfg[CFG_CREG] ? shout_q : chen ? chain_shift_in : route_in[3]; // RULE_23 RULE_21
  wire         arith = fn == ALU_INC || fn == ALU_DEC || fn == ALU_ADD || fn == ALU_SUB;
  wire [3:0]   cidx  = {1'b0, msb} + 4'h1;
  logic [8:0]  sum9;
  logic        bsign;
  logic [7:0]  res_alu;
  logic [7:0]  res_sh;
  logic        shout_c;
  logic        fb;
  wire         carry_c = arith && sum9[cidx];
  wire         ovf_c   = arith && a_m[msb] == bsign && sum9[msb] != a_m[msb]; // RULE_14
  wire [7:0]   res_fin = cfg[CFG_OM] ? res_sh | omask_q : res_sh; // RULE_12

  always_comb begin
    bsign = 1'b0;
    case (fn) // RULE_06 RULE_11
      ALU_INC: sum9 = {1'b0, a_m} + 9'h001;
      ALU_DEC: begin
        sum9  = {1'b0, a_m} - 9'h001;
        bsign = 1'b1;
      end
      ALU_ADD: begin
        sum9  = {1'b0, a_m} + {1'b0, b_m} + {8'h00, cin};
        bsign = b_m[msb];
      end
      ALU_SUB: begin
        sum9  = {1'b0, a_m} - {1'b0, b_m} - {8'h00, cin};
        bsign = !b_m[msb];
      end
      ALU_AND: sum9 = {1'b0, src_a & src_b};
      ALU_OR:  sum9 = {1'b0, src_a | src_b};
      ALU_XOR: sum9 = {1'b0, src_a ^ src_b};
      default: sum9 = {1'b0, src_a};
    endcase
    res_alu = arith ? sum9[7:0] & wmask : sum9[7:0];
  end

  // outside CRC mode the shifter works on the ALU output whatever the function
  always_comb begin
    fb = src_a[msb] ^ sin;
    if (cfg[CFG_CRC]) begin
      // sin carries serial data for CRC; tie it low for PSEUDO_RANDOM_SEQUENCE
      res_sh  = ({src_a[6:0], 1'b0} ^ (fb ? dat_q[0] : 8'h00)) & wmask; // RULE_17 RULE_18
      shout_c = src_a[msb];
    end else begin
      case (sh) // RULE_12 RULE_16
        SH_LEFT: begin
          res_sh  = {res_alu[6:0], sin} & wmask;
          shout_c = res_alu[msb];
        end
        SH_RIGHT: begin
          res_sh  = ((res_alu & wmask) >> 1) | ({7'h00, sin} << msb);
          shout_c = res_alu[0];
        end
        SH_SWAP: begin
          res_sh  = {res_alu[3:0], res_alu[7:4]};
          shout_c = 1'b0;
        end
        default: begin
          res_sh  = res_alu;
          shout_c = 1'b0;
        end
      endcase
    end
  end

  // compares and conditions
  wire [7:0]   c0_b  = cmpsel_q[0] ? acc_q[1] : dat_q[0]; // RULE_13
  wire [7:0]   c1_b  = cmpsel_q[1] ? dat_q[0] : dat_q[1]; // RULE_13
  wire         eq0_l = (acc_q[0] & cmask_q[0]) == (c0_b & cmask_q[0]);
  wire         lt0_l = (acc_q[0] & cmask_q[0]) < (c0_b & cmask_q[0]);
  wire         eq1   = (acc_q[1] & cmask_q[1]) == (c1_b & cmask_q[1]);
  wire         lt1   = (acc_q[1] & cmask_q[1]) < (c1_b & cmask_q[1]);
  // lower cell feeds its result in; this cell is the upper byte
  wire         eq0   = eq0_l && (!chen || chain_eq_in); // RULE_15
  wire         lt0   = lt0_l || (chen && eq0_l && chain_lt_in); // RULE_15
  wire         z0    = acc_q[0] == 8'h00;
  wire         z1    = acc_q[1] == 8'h00;
  wire         ff0   = acc_q[0] == 8'hFF;
  wire         ff1   = acc_q[1] == 8'hFF;
  assign chain_eq_out    = eq0; // RULE_21
  assign chain_lt_out    = lt0;
  assign chain_carry_out = carry_c;
  assign chain_shift_out = shout_c;

  // FIFOs and stall
  logic [1:0]  f_in_vld;
  logic [1:0]  f_in_rdy;
  logic [1:0]  f_out_vld;
  logic [1:0]  f_out_rdy;
  logic [7:0]  f_in_dat [2];
  logic [7:0]  f_out [2];
  logic [1:0]  wr_acc;
  logic [1:0]  wr_dat;
  wire  [1:0]  need_in = dst & {2{ld}} & ~dir;
  wire  [1:0]  bus_fw  = {we[OFS_FIFO1[3:0]], we[OFS_FIFO0[3:0]]};
  wire  [1:0]  bus_fr  = {2{sys_rd && hit_low}} & {sys_addr[3:0] == OFS_FIFO1[3:0], sys_addr[3:0] == OFS_FIFO0[3:0]};
  // a capture into a full output FIFO or a load from an empty input FIFO freezes the whole cycle
  wire         stall   = |(cap & dir & ~f_in_rdy) || |(need_in & ~f_out_vld);
  wire  [15:0] conds   = {f_in_rdy[1], f_out_vld[1], f_in_rdy[0], f_out_vld[0],
                          shout_q, carry_q, ovf_q, ff1, ff0, z1, z0, lt1, eq1, lt0, eq0, stall};
  assign sys_fifo_ready = f_in_rdy & ~dir;

  for (genvar i = 0; i < 2; i++) begin : g_fifo
    assign f_in_vld[i]  = dir[i] ? cap[i] && !stall : bus_fw[i]; // RULE_19 RULE_24
    assign f_in_dat[i]  = dir[i] ? (ctrl_q[CT_CAPACC] ? acc_q[i] : res_fin) : sys_wdata; // RULE_09
    assign f_out_rdy[i] = dir[i] ? bus_fr[i] : need_in[i] && !stall; // RULE_19
    assign wr_acc[i]    = !stall && (ld ? dst == 2'(i + 1) && !dir[i] : dst[i]); // RULE_07
    assign wr_dat[i]    = !stall && ld && dst == 2'b11 && !dir[i]; // RULE_08 RULE_09
    assign acc_d[i]     = we[OFS_ACC0[3:0] + 4'(i)] ? sys_wdata :
                          wr_acc[i] ? (ld ? f_out[i] : res_fin) : acc_q[i];
    assign dat_d[i]     = we[OFS_DAT0[3:0] + 4'(i)] ? sys_wdata : wr_dat[i] ? f_out[i] : dat_q[i];
    byte_fifo #(
      .WIDTH (8),
      .DEPTH (FDEPTH)
    ) u_fifo (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_valid  (f_in_vld[i]),
      .in_ready  (f_in_rdy[i]),
      .in_data   (f_in_dat[i]),
      .out_valid (f_out_vld[i]),
      .out_ready (f_out_rdy[i]),
      .out_data  (f_out[i])
    );
  end

  // routing outputs pick any condition, FIFO status among them
  for (genvar r = 0; r < NUM_ROUTE; r++) begin : g_route
    wire [23:0] osel_all = {osel_q[2], osel_q[1], osel_q[0]};
    assign route_out[r] = conds[osel_all[4*r +: 4]]; // RULE_14 RULE_20 RULE_22
  end

  // product term arrays
  wire  [ARR_IN-1:0]  ain [2];
  logic [ARR_PT-1:0]  pt [2];
  logic [ARR_OUT-1:0] sop [2];
  assign ain[0]   = arr0_in;
  assign ain[1]   = arr1_in;
  assign arr0_out = (areg_q[3:0] & sop_q[0]) | (~areg_q[3:0] & sop[0]); // RULE_05
  assign arr1_out = (areg_q[7:4] & sop_q[1]) | (~areg_q[7:4] & sop[1]); // RULE_05
  for (genvar a = 0; a < 2; a++) begin : g_arr
    logic [ARR_OUT-1:0] memb [ARR_PT];
    for (genvar t = 0; t < ARR_PT; t++) begin : g_pt
      localparam int B = a * ARR_SPAN + t * ARR_STRIDE;
      wire [ARR_IN-1:0] tm = {arr_q[B+1][3:0], arr_q[B]};
      wire [ARR_IN-1:0] cm = {arr_q[B+2], arr_q[B+1][7:4]};
      // a term with no input chosen stays low
      assign pt[a][t] = |(tm | cm) && &(ain[a] | ~tm) && &(~ain[a] | ~cm); // RULE_02 RULE_03
      assign memb[t]  = arr_q[B+3][ARR_OUT-1:0];
    end
    for (genvar o = 0; o < ARR_OUT; o++) begin : g_sum
      logic [ARR_PT-1:0] col;
      for (genvar t = 0; t < ARR_PT; t++) begin : g_col
        assign col[t] = pt[a][t] && memb[t][o];
      end
      assign sop[a][o] = |col; // RULE_01 RULE_04
    end
  end

  // read-back map of the low block
  assign low_v[OFS_ACC0[3:0]]   = acc_q[0]; // RULE_25
  assign low_v[OFS_ACC1[3:0]]   = acc_q[1];
  assign low_v[OFS_DAT0[3:0]]   = dat_q[0];
  assign low_v[OFS_DAT1[3:0]]   = dat_q[1];
  assign low_v[OFS_FIFO0[3:0]]  = dir[0] && f_out_vld[0] ? f_out[0] : 8'h00;
  assign low_v[OFS_FIFO1[3:0]]  = dir[1] && f_out_vld[1] ? f_out[1] : 8'h00;
  assign low_v[OFS_CTRL[3:0]]   = ctrl_q;
  assign low_v[OFS_STAT[3:0]]   = {conds[15:12], ovf_q, carry_q, shout_q, stall};
  assign low_v[OFS_CMASK0[3:0]] = cmask_q[0];
  assign low_v[OFS_CMASK1[3:0]] = cmask_q[1];
  assign low_v[OFS_OMASK[3:0]]  = omask_q;
  assign low_v[OFS_AREG[3:0]]   = areg_q;
  assign low_v[OFS_CMPSEL[3:0]] = cmpsel_q;
  assign low_v[OFS_OSEL[3:0]]   = osel_q[0];
  assign low_v[4'hE]            = osel_q[1];
  assign low_v[4'hF]            = osel_q[2];
  assign sys_rdata              = rdata_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int k = 0; k < 2; k++) begin
        acc_q[k]   <= RST_DATA;
        dat_q[k]   <= RST_DATA;
        cmask_q[k] <= RST_CMASK;
        sop_q[k]   <= '0;
      end
      carry_q <= 1'b0;
      shout_q <= 1'b0;
      ovf_q   <= 1'b0;
      rdata_q <= RST_DATA;
    end else begin
      acc_q   <= acc_d;
      dat_q   <= dat_d;
      sop_q   <= sop; // RULE_05
      rdata_q <= sys_rd ? rd_mux : rdata_q;
      if (we[OFS_CMASK0[3:0]])
        cmask_q[0] <= sys_wdata;
      if (we[OFS_CMASK1[3:0]])
        cmask_q[1] <= sys_wdata;
      if (!stall) begin
        carry_q <= carry_c; // RULE_23
        shout_q <= shout_c; // RULE_23
        ovf_q   <= ovf_c;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_q   <= RST_DATA;
      omask_q  <= RST_DATA;
      areg_q   <= RST_DATA;
      cmpsel_q <= RST_DATA;
      for (int k = 0; k < 3; k++)
        osel_q[k] <= RST_DATA;
      for (int k = 0; k < 16; k++)
        cram_q[k] <= RST_DATA;
      for (int k = 0; k < 64; k++)
        arr_q[k] <= RST_DATA;
    end else begin
      if (we[OFS_CTRL[3:0]])
        ctrl_q <= sys_wdata;
      if (we[OFS_OMASK[3:0]])
        omask_q <= sys_wdata;
      if (we[OFS_AREG[3:0]])
        areg_q <= sys_wdata;
      if (we[OFS_CMPSEL[3:0]])
        cmpsel_q <= sys_wdata;
      for (int k = 0; k < 3; k++)
        if (we[OFS_OSEL[3:0] + 4'(k)])
          osel_q[k] <= sys_wdata;
      if (sys_wr && hit_cram)
        cram_q[sys_addr[3:0]] <= sys_wdata; // RULE_10
      if (sys_wr && hit_arr)
        arr_q[sys_addr[5:0]] <= sys_wdata;
    end
  end

  wire quiet0 = !we[OFS_ACC0[3:0]] && !stall && !ld && dst == 2'b01;
  chk_acc_alu_load: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_06
    quiet0 |=> acc_q[0] == $past(res_fin)) else $error("acc0 missed ALU result");
  chk_inc_step: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_11
    quiet0 && fn == ALU_INC && sh == SH_NONE && !cfg[CFG_CRC] && !cfg[CFG_OM] && !cfg[CFG_SA] && msb == 3'd7
    |=> acc_q[0] == $past(acc_q[0]) + 8'h01) else $error("increment wrong");
  chk_swap_pass: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_12
    quiet0 && fn == ALU_PASS && sh == SH_SWAP && !cfg[CFG_CRC] && !cfg[CFG_OM] && !cfg[CFG_SA]
    |=> acc_q[0] == {$past(acc_q[0][3:0]), $past(acc_q[0][7:4])}) else $error("nibble swap wrong");
  chk_msb_mask: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_16
    quiet0 && arith && sh == SH_NONE && !cfg[CFG_CRC] && !cfg[CFG_OM]
    |=> (acc_q[0] & ~$past(wmask)) == 8'h00) else $error("bits above msb set");
  chk_dat_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_08
    !we[OFS_DAT0[3:0]] && !(ld && dst == 2'b11) |=> dat_q[0] == $past(dat_q[0])) else $error("data reg changed");
  chk_out_fifo_bus: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_19
    dir[0] && bus_fw[0] && !cap[0] |-> !f_in_vld[0]) else $error("bus pushed output fifo");
  chk_route_status: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_20
    osel_q[0][3:0] == 4'hC |-> route_out[0] == f_out_vld[0]) else $error("fifo status not routed");
  chk_chain_eq: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_15
    chen && !chain_eq_in |-> !chain_eq_out
    && (chain_lt_out == (eq0_l ? chain_lt_in : lt0_l))) else $error("compare chain wrong");
  chk_array_reg: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_05
    areg_q[0] && $past(areg_q[0]) |-> arr0_out[0] == $past(sop[0][0])) else $error("registered output wrong");
  chk_carry_reuse: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_23
    !stall && fn == ALU_ADD ##1 cfg[CFG_CREG] |-> cin == $past(carry_c)) else $error("carry not reused");
endmodule

// ---- sim/bus_host.sv ----
/*
 Bus host model: byte register writes and reads on the cell's system port.
 Assumes strobes sampled on the rising edge, read data one cycle later.
*/
`timescale 1ns/1ps
module bus_host (
  input  wire logic       clk_sys,
  input  wire logic [7:0] sys_rdata,
  output logic      [7:0] sys_addr,
  output logic            sys_wr,
  output logic            sys_rd,
  output logic      [7:0] sys_wdata
);
  initial begin
    sys_addr  = 8'h00;
    sys_wr    = 1'b0;
    sys_rd    = 1'b0;
    sys_wdata = 8'h00;
  end
  // bus side of either FIFO direction goes through these two tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sys_addr  <= a;
    sys_wdata <= d;
    sys_wr    <= 1'b1;
    @(posedge clk_sys);
    sys_wr    <= 1'b0;
    // idle data inverted so a stale byte never looks like a write
    sys_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    sys_addr <= a;
    sys_rd   <= 1'b1;
    @(posedge clk_sys);
    sys_rd   <= 1'b0;
    @(posedge clk_sys);
    d = sys_rdata;
  endtask
endmodule

// ---- sim/testbench.sv ----
/*
 Self-checking bench of the logic datapath cell: registers, ALU and shift
 table, FIFO fill, drain, stall and capture, one array term, compare chain.
 Assumes bus_host.
*/
`timescale 1ns/1ps
module testbench;
  import cell_pkg::*;
  logic                 clk_sys  = 1'b0;
  logic                 rst_n    = 1'b0;
  logic [NUM_ROUTE-1:0] route_in = 6'h01;
  logic [ARR_IN-1:0]    arr_in   = 12'h000;
  logic [3:0]           chain_in = 4'h0;
  logic [7:0]           sys_addr, sys_wdata, sys_rdata;
  logic                 sys_wr, sys_rd, st;
  logic [1:0]           fifo_rdy;
  logic [NUM_ROUTE-1:0] route_out;
  logic [ARR_OUT-1:0]   arr0_out;
  int                   error_cnt = 0;
  int                   samples_checked = 0;
  always #12.5 clk_sys = ~clk_sys;
  bus_host host (.clk_sys(clk_sys), .sys_rdata(sys_rdata), .sys_addr(sys_addr), .sys_wr(sys_wr),
                 .sys_rd(sys_rd), .sys_wdata(sys_wdata));
  logic_datapath_cell uut (.clk_sys(clk_sys), .rst_n(rst_n), .sys_addr(sys_addr), .sys_wr(sys_wr),
    .sys_rd(sys_rd), .sys_wdata(sys_wdata), .sys_rdata(sys_rdata), .sys_fifo_ready(fifo_rdy),
    .route_in(route_in), .route_out(route_out), .arr0_in(arr_in), .arr1_in(arr_in),
    .arr0_out(arr0_out), .arr1_out(), .chain_carry_in(chain_in[0]), .chain_shift_in(chain_in[1]),
    .chain_eq_in(chain_in[2]), .chain_lt_in(chain_in[3]), .chain_carry_out(), .chain_shift_out(),
    .chain_eq_out(), .chain_lt_out());
  task automatic check8(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    check8(n, e, d);
  endtask
  // word 0 is live for exactly one edge; word 1 stays empty as a no-op
  task automatic step(output logic s);
    @(posedge clk_sys);
    route_in <= 6'h00;
    #1 s = route_out[0];
    @(posedge clk_sys);
    route_in <= 6'h01;
  endtask
  task automatic t_regs;
    rd_chk("acc0 reset", OFS_ACC0, RST_DATA);
    rd_chk("cmask0 reset", OFS_CMASK0, RST_CMASK);
    for (int i = 0; i < 4; i++) host.wr(OFS_ACC0 + 8'(i), 8'hA0 + 8'(i));
    for (int i = 0; i < 4; i++) rd_chk("work reg", OFS_ACC0 + 8'(i), 8'hA0 + 8'(i));
    host.wr(8'h20, 8'h5A);
    rd_chk("unmapped", 8'h20, 8'h00);
  endtask
  task automatic t_alu;
    logic [7:0] lo [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h47, 8'h87, 8'hC7};
    logic [7:0] ex [11] = '{8'h3D, 8'h3B, 8'h4B, 8'h2D, 8'h0C, 8'h3F, 8'h33, 8'h3C, 8'h78, 8'h1E, 8'hC3};
    host.wr(OFS_CTRL, 8'h1C);
    host.wr(OFS_DAT0, 8'h0F);
    for (int i = 0; i < 11; i++) begin
      host.wr(OFS_ACC0, 8'h3C);
      host.wr(OFS_CRAM, lo[i]);
      host.wr(OFS_CRAM + 8'h01, 8'h02);
      step(st);
      rd_chk("alu result", OFS_ACC0, ex[i]);
    end
    rd_chk("data0 kept", OFS_DAT0, 8'h0F);
    // msb at bit 3 turns acc0 into a four-bit counter that wraps
    host.wr(OFS_CTRL, 8'h0C);
    host.wr(OFS_ACC0, 8'h0F);
    host.wr(OFS_CRAM, 8'h00);
    step(st);
    rd_chk("msb wrap", OFS_ACC0, 8'h00);
  endtask
  task automatic t_fifo;
    #1 check8("ready empty", 8'h01, {7'h00, fifo_rdy[0]});
    host.wr(OFS_OSEL, 8'hC0);
    for (int i = 0; i < 4; i++) host.wr(OFS_FIFO0, 8'h11 * 8'(i + 1));
    #1 check8("ready full", 8'h00, {7'h00, fifo_rdy[0]});
    check8("route not empty", 8'h01, {7'h00, route_out[1]});
    // software tests ready first; a full input buffer gets no write
    if (fifo_rdy[0]) host.wr(OFS_FIFO0, 8'h99);
    rd_chk("fifo in read", OFS_FIFO0, 8'h00);
    host.wr(OFS_CRAM, 8'h07);
    host.wr(OFS_CRAM + 8'h01, 8'h0A);
    for (int i = 0; i < 4; i++) begin
      step(st);
      check8("no stall", 8'h00, {7'h00, st});
      rd_chk("fifo load", OFS_ACC0, 8'h11 * 8'(i + 1));
    end
    #1 check8("ready drained", 8'h01, {7'h00, fifo_rdy[0]});
    check8("route empty", 8'h00, {7'h00, route_out[1]});
    step(st);
    check8("stall out", 8'h01, {7'h00, st});
    rd_chk("frozen acc0", OFS_ACC0, 8'h44);
    // fifo1 turned output buffer: one pass of acc0 captured, bus drains it
    host.wr(OFS_CTRL, 8'h1E);
    host.wr(OFS_CRAM, 8'h07);
    host.wr(OFS_CRAM + 8'h01, 8'h20);
    #1 check8("out ready", 8'h00, {7'h00, fifo_rdy[1]});
    step(st);
    check8("capture stall", 8'h00, {7'h00, st});
    rd_chk("fifo capture", OFS_FIFO1, 8'h44);
  endtask
  task automatic t_array;
    host.wr(OFS_ARR, 8'h01);
    host.wr(OFS_ARR + 8'h03, 8'h01);
    host.wr(OFS_AREG, 8'h00);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk_sys);
      arr_in <= 12'(v);
      #1 check8("array out", 8'(v), {7'h00, arr0_out[0]});
    end
    // registered output lags the input by one edge
    host.wr(OFS_AREG, 8'h01);
    @(posedge clk_sys);
    arr_in <= 12'h000;
    #1 check8("array held", 8'h01, {7'h00, arr0_out[0]});
    @(posedge clk_sys);
    #1 check8("array reg", 8'h00, {7'h00, arr0_out[0]});
  endtask
  // equal upper bytes defer to the lower cell; unequal ones decide alone
  task automatic t_chain;
    host.wr(OFS_CTRL, 8'h3C);
    host.wr(OFS_ACC0, 8'h44);
    host.wr(OFS_DAT0, 8'h44);
    host.wr(OFS_OSEL, 8'h12);
    @(posedge clk_sys);
    chain_in <= 4'h4;
    #1 check8("chain equal", 8'h02, {6'h00, route_out[1:0]});
    @(posedge clk_sys);
    chain_in <= 4'h8;
    #1 check8("chain low lt", 8'h01, {6'h00, route_out[1:0]});
    host.wr(OFS_DAT0, 8'h45);
    @(posedge clk_sys);
    chain_in <= 4'h4;
    #1 check8("chain high lt", 8'h01, {6'h00, route_out[1:0]});
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_alu();
    t_fifo();
    t_array();
    t_chain();
    finish_test();
  end
  // run is a few hundred cycles; this bound only cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    $display("[FAIL] watchdog expected done seen hang");
    finish_test();
  end
endmodule
